// File: bench/processor_system_bus_interface_bench.sv
// Self-checking bench for the processor system bus interface.
// Assumes psbi_pkg and the agent model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module processor_system_bus_interface_bench;
    import psbi_pkg::*;
    logic        clock, rst_b, por_n, warm_n, ref_clk, req_valid;
    logic [1:0]  ratio;
    logic [4:0]  int_n;
    psbi_cycle_t req_cycle;
    wire logic [31:0] ad_o, ad_oe, ag_ad, bus_ad, cause, rd_data, ext_a, ext_d;
    wire logic [4:0]  cmd_o, cmd_oe, ag_cmd, bus_cmd;
    wire logic [2:0]  halves;
    wire logic tclk, pll_n, hold, pv_n, av_n, proc_bus_request_n_n, areq_n, owns_n, acc_n, req_ready;
    wire logic rd_valid, rd_last, ext_valid, perr;
    int          errors = 0;
    int          checked = 0;
    int          ext_cnt = 0;
    logic [32:0] rd_q[$];
    logic [2:0]  exp_half[4] = '{HALF_1_0, HALF_1_5, HALF_2_0, HALF_3_0};
    bit          ok;

    assign bus_ad  = (ad_o & ad_oe) | (ag_ad & ~ad_oe);
    assign bus_cmd = (cmd_o & cmd_oe) | (ag_cmd & ~cmd_oe);

    psbi_top i_dut (.CLOCK(clock), .RST_B(rst_b), .POWER_ON_RESET_N(por_n),
        .WARM_RESET_N(warm_n), .INPUT_REF_CLK(ref_clk), .TRANSMIT_CLK(tclk),
        .PLL_RESET_N(pll_n), .WARM_RESET_HOLD(hold), .CLOCK_RATIO_SELECT(ratio),
        .PIPE_RATIO_HALVES(halves), .INT_N(int_n), .EXC_CAUSE(cause),
        .SHARED_ADDR_DATA_BUS_I(bus_ad), .SHARED_ADDR_DATA_BUS_O(ad_o),
        .SHARED_ADDR_DATA_BUS_OE(ad_oe), .COMMAND_IDENT_BUS_I(bus_cmd),
        .COMMAND_IDENT_BUS_O(cmd_o), .COMMAND_IDENT_BUS_OE(cmd_oe),
        .AGENT_VALID_N(av_n), .PROC_VALID_N(pv_n), .AGENT_BUS_REQUEST_N(areq_n),
        .PROC_BUS_REQUEST_N(proc_bus_request_n_n), .PROC_OWNS_BUS_N(owns_n),
        .AGENT_ACCEPT_READY_N(acc_n), .REQ_CYCLE(req_cycle), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .RD_LAST(rd_last), .EXT_WR_ADDR(ext_a), .EXT_WR_DATA(ext_d),
        .EXT_WR_VALID(ext_valid), .PROTOCOL_ERROR(perr));

    psbi_agent i_agent (.link_clk(ref_clk), .owns_n(owns_n), .proc_valid_n(pv_n),
        .bus_ad(bus_ad), .bus_cmd(bus_cmd), .ag_ad(ag_ad), .ag_cmd(ag_cmd),
        .ag_valid_n(av_n), .ag_req_n(areq_n), .ag_accept_n(acc_n));

    // ************************************************************
    // Clocks, monitors and helpers
    // ************************************************************
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        ref_clk = 1'b0;
        #13;
        forever #160 ref_clk = ~ref_clk;
    end

    always @(posedge clock) begin
        if (rd_valid === 1'b1) begin
            rd_q.push_back({rd_last, rd_data});
        end
        ext_cnt += int'(ext_valid === 1'b1);
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic push(input logic [4:0] c, input logic [31:0] a);
        logic rdy = 1'b0;
        req_cycle <= {c, a};
        req_valid <= 1'b1;
        for (int n = 0; n < 200 && !rdy; n++) begin
            @(negedge clock);
            rdy = req_ready;
            @(posedge clock);
        end
        `CHK(rdy, 1'b1)
    endtask

    task automatic chk_seen(input int i, input logic [4:0] c, input logic [31:0] a);
        `CHK(i_agent.seen_q[i], psbi_cycle_t'({c, a}))
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_misc();
        `CHK({owns_n, pv_n, proc_bus_request_n_n, req_ready, perr}, 5'h0E)
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            ratio <= 2'(i);
            int_n <= 5'(i * 7 + 3);
            repeat (5) @(posedge clock);
            @(negedge clock);
            `CHK(halves, exp_half[i])
            `CHK(cause, {17'h0_0000, ~5'(i * 7 + 3), 10'h000})
        end
        @(posedge clock);
        warm_n <= 1'b0;
        repeat (5) @(posedge clock);
        `CHK(hold, 1'b1)
        warm_n <= 1'b1;
        por_n  <= 1'b0;
        repeat (5) @(posedge clock);
        `CHK(pll_n, 1'b0)
        por_n <= 1'b1;
        repeat (6) @(posedge clock);
        `CHK({hold, pll_n, owns_n}, 3'h2)
        $display("test misc done");
    endtask

    task automatic t_write();
        i_agent.set_accept(1'b1);
        @(posedge clock);
        push(5'h08, 32'h0000_0400);
        push(5'h10, 32'hA5A5_0001);
        req_valid <= 1'b0;
        repeat (24) @(negedge clock);
        `CHK({req_ready, 32'(i_agent.seen_q.size())}, 33'h0)
        i_agent.set_accept(1'b0);
        @(posedge clock);
        push(5'h18, 32'hA5A5_0002);
        req_valid <= 1'b0;
        for (int i = 0; i < 400 && i_agent.seen_q.size() < 3; i++) @(posedge clock);
        repeat (40) @(posedge clock);
        `CHK(i_agent.seen_q.size(), 3)
        chk_seen(0, 5'h08, 32'h0000_0400);
        chk_seen(1, 5'h10, 32'hA5A5_0001);
        chk_seen(2, 5'h18, 32'hA5A5_0002);
        $display("test write done");
    endtask

    task automatic t_read();
        i_agent.seen_q.delete();
        push(5'h00, 32'h0000_1000);
        push(5'h08, 32'h0000_2000);
        push(5'h18, 32'hCAFE_0001);
        req_valid <= 1'b0;
        repeat (80) @(posedge clock);
        `CHK({owns_n, 32'(i_agent.seen_q.size())}, 33'h1_0000_0001)
        i_agent.read_resp(4, 32'h5A00_0000, ok);
        `CHK(ok, 1'b1)
        for (int i = 0; i < 200 && i_agent.seen_q.size() < 3; i++) @(posedge clock);
        `CHK(rd_q.size(), 4)
        for (int i = 0; i < 4; i++) begin
            `CHK(rd_q[i], {1'(i == 3), 32'h5A00_0000 + 32'(i)})
        end
        chk_seen(0, 5'h00, 32'h0000_1000);
        chk_seen(1, 5'h08, 32'h0000_2000);
        chk_seen(2, 5'h18, 32'hCAFE_0001);
        $display("test read done");
    endtask

    task automatic t_ext();
        logic a;
        i_agent.ext_write(32'h0000_0300, 32'h1234_5678, ok);
        repeat (24) @(negedge clock);
        `CHK({ok, ext_a, ext_d}, {1'b1, 32'h0000_0300, 32'h1234_5678})
        `CHK({owns_n, perr}, 2'h0)
        i_agent.bad_valid();
        repeat (24) @(posedge clock);
        `CHK(perr, 1'b1)
        `CHK(ext_cnt, 1)
        @(negedge ref_clk);
        a = proc_bus_request_n_n;
        @(negedge ref_clk);
        `CHK(proc_bus_request_n_n, ~a)
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(negedge clock);
        `CHK({perr, proc_bus_request_n_n, owns_n, pv_n}, 4'h5)
        $display("test external done");
    endtask

    task automatic t_tclk();
        int rises = 0;
        int highs = 0;
        logic prev = tclk;
        repeat (64) begin
            @(posedge clock);
            rises += int'(prev === 1'b0 && tclk === 1'b1);
            highs += int'(tclk === 1'b1);
            prev = tclk;
        end
        `CHK({rises, highs}, {32'd8, 32'd32})
        $display("test transmit clock done");
    endtask

    initial begin
        #400_000;
        errors++;
        complete_run();
    end

    initial begin
        {rst_b, por_n, warm_n, req_valid, ratio, int_n} = 11'h31F;
        req_cycle = '0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(negedge clock);
        t_misc();
        t_write();
        t_read();
        t_ext();
        t_tclk();
        complete_run();
    end
endmodule
`default_nettype wire

// File: bench/psbi_agent.sv
// Behavioural external agent facing the processor system bus.
// Assumes it is stepped by the free-running link clock and that the bench
// resolves the shared buses from the design's enables and this model.
`timescale 1ns/1ps
`default_nettype none
module psbi_agent (
    input  wire logic                       link_clk,
    input  wire logic                       owns_n,
    input  wire logic                       proc_valid_n,
    input  wire logic [psbi_pkg::AD_W-1:0]  bus_ad,
    input  wire logic [psbi_pkg::CMD_W-1:0] bus_cmd,
    output logic      [psbi_pkg::AD_W-1:0]  ag_ad,
    output logic      [psbi_pkg::CMD_W-1:0] ag_cmd,
    output logic                            ag_valid_n,
    output logic                            ag_req_n,
    output logic                            ag_accept_n
);
    import psbi_pkg::*;
    psbi_cycle_t seen_q[$];

    // ************************************************************
    // Pins change mid link period, stable around each rising edge
    // ************************************************************
    initial begin
        ag_ad       = 32'h0000_0000;
        ag_cmd      = 5'h00;
        ag_valid_n  = 1'b1;
        ag_req_n    = 1'b1;
        ag_accept_n = 1'b0;
    end

    always @(negedge link_clk) begin
        if (proc_valid_n === 1'b0) begin
            seen_q.push_back({bus_cmd, bus_ad});
        end
    end

    task automatic drive(input logic [4:0] c, input logic [31:0] a);
        @(negedge link_clk);
        ag_valid_n = 1'b0;
        ag_cmd     = c;
        ag_ad      = a;
    endtask

    task automatic release_bus();
        @(negedge link_clk);
        ag_valid_n = 1'b1;
        ag_ad      = ~ag_ad;
        ag_cmd     = ~ag_cmd;
    endtask

    task automatic wait_slave(output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(negedge link_clk);
            ok = (owns_n === 1'b1);
        end
    endtask

    task automatic set_accept(input logic v);
        @(negedge link_clk);
        ag_accept_n = v;
    endtask

    task automatic read_resp(input int n, input logic [31:0] base, output bit ok);
        wait_slave(ok);
        for (int i = 0; i < n && ok; i++) begin
            drive({CYC_DATA, 1'(i == n - 1), 3'h0}, base + 32'(i));
        end
        release_bus();
    endtask

    task automatic ext_write(input logic [31:0] a, input logic [31:0] d, output bit ok);
        @(negedge link_clk);
        ag_req_n = 1'b0;
        wait_slave(ok);
        ag_req_n = 1'b1;
        drive(5'h08, a);
        drive(5'h18, d);
        release_bus();
    endtask

    // Deliberate fault: valid strobe while the processor owns the bus
    task automatic bad_valid();
        drive(5'h08, 32'hDEAD_0000);
        release_bus();
    endtask
endmodule
`default_nettype wire

// File: hdl/psbi_pkg.sv
// Constants and carrier types of the processor system bus interface.
// Assumes a single 25 MHz system clock; the link clock is sampled, not used as a clock.
package psbi_pkg;

    // ************************************************************
    // Bus shape
    // ************************************************************
    localparam int AD_W         = 32;
    localparam int CMD_W        = 5;
    localparam int CMD_TYPE_BIT = 4;
    localparam int CMD_WR_BIT   = 3;
    localparam int ID_LAST_BIT  = 3;
    localparam logic CYC_ADDR   = 1'b0;
    localparam logic CYC_DATA   = 1'b1;
    localparam int CAUSE_IP_LO  = 10;
    localparam int CAUSE_IP_HI  = 14;
    localparam int BUF_DEPTH    = 2;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [AD_W-1:0]  AD_RST    = 32'h0000_0000;
    localparam logic [CMD_W-1:0] CMD_RST   = 5'h00;

    // ************************************************************
    // Clock ratio codes and pipeline ratio in half steps
    // ************************************************************
    localparam logic [1:0] RATIO_1_0 = 2'h0;
    localparam logic [1:0] RATIO_1_5 = 2'h1;
    localparam logic [1:0] RATIO_2_0 = 2'h2;
    localparam logic [1:0] RATIO_3_0 = 2'h3;
    localparam logic [2:0] HALF_1_0  = 3'h2;
    localparam logic [2:0] HALF_1_5  = 3'h3;
    localparam logic [2:0] HALF_2_0  = 3'h4;
    localparam logic [2:0] HALF_3_0  = 3'h6;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [CMD_W-1:0] cmd;
        logic [AD_W-1:0]  ad;
    } psbi_cycle_t;

    typedef enum logic [2:0] {
        ST_MASTER = 3'b001,
        ST_WRITE  = 3'b010,
        ST_SLAVE  = 3'b100
    } psbi_state_t;

endpackage

// File: hdl/psbi_top.sv
// Processor side of the system bus: issues requests, arbitrates mastership,
// takes read responses and agent writes. All pins but POWER_ON_RESET_N are sampled by CLOCK;
// bus cycles advance on each rising edge found on INPUT_REF_CLK.
//
// Operation
// - Agent cannot reach cache tags or contents
// - Shared 32-bit bus plus 5-bit command bus
// - Processor valid strobe marks its valid cycles
// - Processor request output asks for ownership
// - Protocol error toggles request output continuously
// - Mastership output low while processor is master
// - Interrupt inputs appear at cause bits 14:10
// - Warm reset held while input asserted
// - Cold reset asynchronous, also resets the PLL
// - Transmit clock follows master clock
// - Ratio select picks 1, 1.5, 2, 3
// - Each party drives buses only while owning
// - No new request while read pending
// - Read done at last response, write at last word
// - Read data accepted whenever it arrives
// - Processor default master; agent returns mastership
// - Data accepted on every consecutive bus cycle
// - System events issue one or more requests
// - Processor write has address plus data words
// - Command top bit: address or data cycle
// - Outputs registered, inputs captured by registers
// - Release after read, regain at last response
`timescale 1ns/1ps
`default_nettype none
module psbi_top (
    input  wire logic                      CLOCK,
    input  wire logic                      RST_B,
    input  wire logic                      POWER_ON_RESET_N,
    input  wire logic                      WARM_RESET_N,
    input  wire logic                      INPUT_REF_CLK,
    output logic                           TRANSMIT_CLK,
    output logic                           PLL_RESET_N,
    output logic                           WARM_RESET_HOLD,
    input  wire logic [1:0]                CLOCK_RATIO_SELECT,
    output logic [2:0]                     PIPE_RATIO_HALVES,
    input  wire logic [4:0]                INT_N,
    output logic [31:0]                    EXC_CAUSE,
    input  wire logic [psbi_pkg::AD_W-1:0] SHARED_ADDR_DATA_BUS_I,
    output logic [psbi_pkg::AD_W-1:0]      SHARED_ADDR_DATA_BUS_O,
    output logic [psbi_pkg::AD_W-1:0]      SHARED_ADDR_DATA_BUS_OE,
    input  wire logic [psbi_pkg::CMD_W-1:0] COMMAND_IDENT_BUS_I,
    output logic [psbi_pkg::CMD_W-1:0]     COMMAND_IDENT_BUS_O,
    output logic [psbi_pkg::CMD_W-1:0]     COMMAND_IDENT_BUS_OE,
    input  wire logic                      AGENT_VALID_N,
    output logic                           PROC_VALID_N,
    input  wire logic                      AGENT_BUS_REQUEST_N,
    output logic                           PROC_BUS_REQUEST_N,
    output logic                           PROC_OWNS_BUS_N,
    input  wire logic                      AGENT_ACCEPT_READY_N,
    input  wire psbi_pkg::psbi_cycle_t     REQ_CYCLE,
    input  wire logic                      REQ_VALID,
    output logic                           REQ_READY,
    output logic [psbi_pkg::AD_W-1:0]      RD_DATA,
    output logic                           RD_VALID,
    output logic                           RD_LAST,
    output logic [psbi_pkg::AD_W-1:0]      EXT_WR_ADDR,
    output logic [psbi_pkg::AD_W-1:0]      EXT_WR_DATA,
    output logic                           EXT_WR_VALID,
    output logic                           PROTOCOL_ERROR
);
    import psbi_pkg::*;

    // ************************************************************
    // Cold reset: asynchronous assert, synchronous release
    // ************************************************************
    logic cold_ff1_reg;
    logic cold_ff2_reg;
    always_ff @(posedge CLOCK or negedge POWER_ON_RESET_N) begin
        if (!POWER_ON_RESET_N) begin
            cold_ff1_reg <= 1'b0;
            cold_ff2_reg <= 1'b0;
        end else begin
            cold_ff1_reg <= 1'b1;
            cold_ff2_reg <= cold_ff1_reg;
        end
    end
    assign PLL_RESET_N = cold_ff2_reg;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam int SYN_W = AD_W + CMD_W + 12;
    logic [SYN_W-1:0] syn1_reg;
    logic [SYN_W-1:0] syn2_reg;
    logic             ref_prev_reg;
    // Command above address so the top slice lines up with the carrier struct
    wire  [SYN_W-1:0] syn_in = {COMMAND_IDENT_BUS_I, SHARED_ADDR_DATA_BUS_I, AGENT_VALID_N,
                                AGENT_BUS_REQUEST_N, AGENT_ACCEPT_READY_N, INT_N,
                                CLOCK_RATIO_SELECT, WARM_RESET_N, INPUT_REF_CLK};
    always_ff @(posedge CLOCK) begin
        syn1_reg     <= syn_in;
        syn2_reg     <= syn1_reg;
        ref_prev_reg <= syn2_reg[0];
    end
    wire              ref_s    = syn2_reg[0];
    wire              warm_n_s = syn2_reg[1];
    wire [1:0]        ratio_s  = syn2_reg[3:2];
    wire [4:0]        int_n_s  = syn2_reg[8:4];
    wire              eok_n_s  = syn2_reg[9];
    wire              agent_bus_request_n_n_s = syn2_reg[10];
    wire              evld_n_s = syn2_reg[11];
    wire psbi_cycle_t ext_s    = syn2_reg[SYN_W-1:12];
    wire              lr       = ref_s & ~ref_prev_reg;
    wire              rst_int  = RST_B & warm_n_s & cold_ff2_reg;

    // ************************************************************
    // Clock, reset and interrupt side outputs
    // ************************************************************
    logic [2:0]  ratio_next;
    logic        tclk_reg;
    logic        warm_hold_reg;
    logic [2:0]  ratio_reg;
    logic [31:0] cause_reg;
    always_comb begin
        case (ratio_s)
            RATIO_1_0: ratio_next = HALF_1_0;
            RATIO_1_5: ratio_next = HALF_1_5;
            RATIO_2_0: ratio_next = HALF_2_0;
            RATIO_3_0: ratio_next = HALF_3_0;
            default:   ratio_next = HALF_1_0;
        endcase
    end
    always_ff @(posedge CLOCK) begin
        tclk_reg      <= ref_s;
        warm_hold_reg <= ~warm_n_s;
        ratio_reg     <= ratio_next;
        cause_reg     <= AD_RST;
        cause_reg[CAUSE_IP_HI:CAUSE_IP_LO] <= ~int_n_s;
    end
    assign TRANSMIT_CLK      = tclk_reg;
    assign WARM_RESET_HOLD   = warm_hold_reg;
    assign PIPE_RATIO_HALVES = ratio_reg;
    assign EXC_CAUSE         = cause_reg;

    // ************************************************************
    // Two-entry request buffer
    // ************************************************************
    psbi_cycle_t buf_mem [BUF_DEPTH];
    logic        wr_ptr_reg;
    logic        rd_ptr_reg;
    logic [1:0]  cnt_reg;
    logic        pop;
    wire         push     = REQ_VALID & REQ_READY;
    wire         head_vld = (cnt_reg != 2'h0);
    psbi_cycle_t head;
    assign head      = buf_mem[rd_ptr_reg];
    assign REQ_READY = (cnt_reg != 2'h2);
    always_ff @(posedge CLOCK) begin
        if (push) begin
            buf_mem[wr_ptr_reg] <= REQ_CYCLE;
        end
        if (!rst_int) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg    <= 2'h0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            cnt_reg    <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // ************************************************************
    // Bus state machine, one step per link cycle
    // ************************************************************
    psbi_state_t state_reg;
    psbi_state_t state_next;
    logic        owns_n_reg;
    logic        pvld_n_reg;
    logic        proc_bus_request_n_n_reg;
    logic        pend_reg;
    logic        ext_seen_reg;
    logic        err_reg;
    psbi_cycle_t drv_reg;
    logic        rd_valid_reg;
    logic        rd_last_reg;
    logic [31:0] rd_data_reg;
    logic        ewr_valid_reg;
    logic [31:0] ewr_addr_reg;
    logic [31:0] ewr_data_reg;

    wire head_addr  = head_vld & (head.cmd[CMD_TYPE_BIT] == CYC_ADDR);
    wire head_wr    = head.cmd[CMD_WR_BIT];
    wire agent_req  = ~agent_bus_request_n_n_s;
    wire agent_vld  = ~evld_n_s;
    wire agent_data = agent_vld & (ext_s.cmd[CMD_TYPE_BIT] == CYC_DATA);
    wire agent_last = ext_s.cmd[ID_LAST_BIT];
    wire in_master  = (state_reg == ST_MASTER);
    wire in_write   = (state_reg == ST_WRITE);
    wire in_slave   = (state_reg == ST_SLAVE);
    // Agent request wins over a queued processor request
    wire can_issue  = in_master & head_addr & ~eok_n_s & ~agent_req & ~pend_reg;
    wire wr_data    = in_write & head_vld;
    wire issue      = lr & (can_issue | wr_data);
    wire rd_take    = in_slave & agent_data & ~ext_seen_reg & pend_reg;
    wire ewr_take   = in_slave & agent_data & ext_seen_reg;
    wire ext_addr   = in_slave & agent_vld & ~agent_data;
    wire bad_cycle  = (agent_vld & ~owns_n_reg)
                    | (in_slave & agent_data & ~ext_seen_reg & ~pend_reg);
    wire rd_done    = rd_take & agent_last;
    wire wr_done    = wr_data & head.cmd[ID_LAST_BIT];
    wire want_bus   = in_slave & head_vld & ~pend_reg;
    assign pop = issue | (lr & in_master & head_vld & ~head_addr);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_MASTER: begin
                if (agent_req) begin
                    state_next = ST_SLAVE;
                end else if (can_issue) begin
                    state_next = head_wr ? ST_WRITE : ST_SLAVE;
                end
            end
            ST_WRITE: begin
                if (wr_done) begin
                    state_next = ST_MASTER;
                end
            end
            ST_SLAVE: begin
                if (rd_done | ewr_take) begin
                    state_next = ST_MASTER;
                end
            end
            default: state_next = ST_MASTER;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!rst_int) begin
            state_reg  <= ST_MASTER;
            owns_n_reg <= 1'b0;
            pvld_n_reg <= 1'b1;
            proc_bus_request_n_n_reg <= 1'b1;
            pend_reg   <= 1'b0;
            ext_seen_reg <= 1'b0;
            err_reg    <= 1'b0;
            drv_reg    <= {CMD_RST, AD_RST};
        end else if (lr) begin
            state_reg  <= state_next;
            // A read address keeps the bus for its own cycle; release follows next step
            owns_n_reg <= (state_next == ST_SLAVE) & ~can_issue;
            pvld_n_reg <= ~(can_issue | wr_data);
            if (can_issue | wr_data) begin
                drv_reg <= head;
            end
            err_reg    <= err_reg | bad_cycle;
            proc_bus_request_n_n_reg <= err_reg ? ~proc_bus_request_n_n_reg : ~want_bus;
            if (can_issue & ~head_wr) begin
                pend_reg <= 1'b1;
            end else if (rd_done) begin
                pend_reg <= 1'b0;
            end
            if (ext_addr) begin
                ext_seen_reg <= 1'b1;
            end else if (ewr_take) begin
                ext_seen_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Delivered data, one CLOCK pulse each
    // ************************************************************
    always_ff @(posedge CLOCK) begin
        if (!rst_int) begin
            rd_valid_reg  <= 1'b0;
            rd_last_reg   <= 1'b0;
            rd_data_reg   <= AD_RST;
            ewr_valid_reg <= 1'b0;
            ewr_addr_reg  <= AD_RST;
            ewr_data_reg  <= AD_RST;
        end else begin
            rd_valid_reg  <= lr & rd_take;
            ewr_valid_reg <= lr & ewr_take;
            if (lr & rd_take) begin
                rd_data_reg <= ext_s.ad;
                rd_last_reg <= agent_last;
            end
            if (lr & ext_addr) begin
                ewr_addr_reg <= ext_s.ad;
            end
            if (lr & ewr_take) begin
                ewr_data_reg <= ext_s.ad;
            end
        end
    end

    assign SHARED_ADDR_DATA_BUS_O  = drv_reg.ad;
    assign COMMAND_IDENT_BUS_O     = drv_reg.cmd;
    assign SHARED_ADDR_DATA_BUS_OE = {AD_W{~owns_n_reg}};
    assign COMMAND_IDENT_BUS_OE    = {CMD_W{~owns_n_reg}};
    assign PROC_VALID_N            = pvld_n_reg;
    assign PROC_BUS_REQUEST_N      = proc_bus_request_n_n_reg;
    assign PROC_OWNS_BUS_N         = owns_n_reg;
    assign RD_DATA                 = rd_data_reg;
    assign RD_VALID                = rd_valid_reg;
    assign RD_LAST                 = rd_last_reg;
    assign EXT_WR_ADDR             = ewr_addr_reg;
    assign EXT_WR_DATA             = ewr_data_reg;
    assign EXT_WR_VALID            = ewr_valid_reg;
    assign PROTOCOL_ERROR          = err_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!rst_int);

    sequence s_read_issue;
        issue && in_master && !head_wr;
    endsequence
    sequence s_released;
        ##[1:20] owns_n_reg;
    endsequence

    AST_VALID_WHILE_OWNER: assert property (!pvld_n_reg |-> !owns_n_reg && SHARED_ADDR_DATA_BUS_OE[0])
        else $error("valid strobe without bus ownership");
    AST_NO_ISSUE_PENDING: assert property (issue |-> !pend_reg)
        else $error("request issued while read pending");
    AST_RELEASE_AFTER_READ: assert property (s_read_issue |-> s_released)
        else $error("mastership not released after read");
    AST_ERR_TOGGLES: assert property (err_reg && lr |=> proc_bus_request_n_n_reg != $past(proc_bus_request_n_n_reg))
        else $error("request not toggling on protocol error");
    AST_CAUSE_BITS: assert property ($stable(int_n_s) |=> cause_reg[14:10] == ~$past(int_n_s))
        else $error("cause bits do not follow interrupts");
    AST_RATIO_3: assert property (ratio_s == RATIO_3_0 |=> PIPE_RATIO_HALVES == HALF_3_0)
        else $error("ratio 3 not selected");
    AST_READ_TAKEN: assert property (lr && rd_take |=> RD_VALID && RD_DATA == $past(ext_s.ad))
        else $error("read data not taken");
    AST_REGAIN_AFTER_READ: assert property (lr && rd_done |=> !owns_n_reg && !pend_reg)
        else $error("mastership not regained after last response");
    AST_TCLK_FOLLOWS: assert property (ref_s |=> TRANSMIT_CLK)
        else $error("transmit clock not following reference");
    AST_RESET_STATE: assert property (@(posedge CLOCK) disable iff (!cold_ff2_reg)
        !RST_B |=> !owns_n_reg && pvld_n_reg && !pend_reg)
        else $error("reset state wrong");
    AST_WARM_HOLD: assert property (@(posedge CLOCK) disable iff (!cold_ff2_reg)
        !warm_n_s [*2] |-> WARM_RESET_HOLD)
        else $error("warm reset not held");

endmodule
`default_nettype wire
